/* rtl/rre_pkg.sv */
// Package with operation codes, widths and carrier structs for the return/rotate unit
package rre_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int STACK_DEPTH = 4;
  localparam int MSB_POS = 7;
  localparam int LSB_POS = 0;
  localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic GIE_RESET = 1'b0;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 11'h004;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_RETURN = 4'h1,
    OP_RETURN_LOAD_IMMEDIATE = 4'h2,
    OP_RETURN_FROM_INTERRUPT = 4'h3,
    OP_ROTATE_LEFT_MEM = 4'h4,
    OP_ROTATE_LEFT_TO_WREG = 4'h5,
    OP_ROTATE_LEFT_THRU_CARRY = 4'h6,
    OP_ROTATE_LEFT_THRU_CARRY_TO_WREG = 4'h7,
    OP_ROTATE_RIGHT_MEM = 4'h8,
    OP_CALL = 4'h9
  } rre_op_t;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_MEMREAD = 3'b010,
    ST_IRQ = 3'b100
  } rre_state_t;

  typedef struct packed {
    logic valid;
    rre_op_t op;
    logic [DATA_W-1:0] imm;
    logic [DATA_W-1:0] addr;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] nextPc;
  } rre_instr_t;

  typedef struct packed {
    logic we;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rre_memwr_t;
endpackage

/* rtl/rre_stack.sv */
// Return address stack with push and pop
module rre_stack #(
  parameter int DEPTH = rre_pkg::STACK_DEPTH,
  parameter int WIDTH = rre_pkg::PC_W
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] pushData,
  output logic [WIDTH-1:0] topData
);
  import rre_pkg::*;
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] ptr;
  } rre_stk_t;
  rre_stk_t st;
  rre_stk_t next_st;
  logic [PW-1:0] topIdx;

  always_comb begin
    topIdx = st.ptr - 1'b1;
    topData = st.mem[topIdx];
    next_st = st;
    if (push) begin
      next_st.mem[st.ptr] = pushData;
      next_st.ptr = st.ptr + 1'b1;
    end else if (pop) begin
      // Wraps on underflow like a circular stack
      next_st.ptr = topIdx;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule

/* rtl/rre_core.sv */
// Execution unit for return and rotate instructions
// How it works
// - Return-with-immediate pops PC, loads immediate into working register, flags untouched.
// - Return-from-interrupt pops PC and sets global interrupt enable to one.
// - Pending interrupt at return-from-interrupt is serviced before main program resumes.
// - Rotate-left-mem rotates byte left, bit 7 into bit 0, writes back.
// - Rotate-left-to-wreg puts left-rotated byte in working register only.
// - Through-carry rotate: old carry to bit 0, bit 7 to carry, write back.
// - Through-carry to wreg: result to working register, carry from bit 7.
// - Rotate-right-mem rotates byte right, bit 0 into bit 7, writes back.
// - Plain return restores PC from stack, no flags changed.
module rre_core (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input rre_pkg::rre_instr_t instr,
  input wire logic irqPending,
  input wire logic [rre_pkg::DATA_W-1:0] memRdata,
  output logic busy,
  output logic [rre_pkg::PC_W-1:0] pc,
  output logic [rre_pkg::DATA_W-1:0] wreg,
  output logic carry,
  output logic globalIntEnable,
  output logic irqAck,
  output logic [rre_pkg::DATA_W-1:0] memRaddr,
  output rre_pkg::rre_memwr_t memWr
);
  import rre_pkg::*;

  typedef struct packed {
    rre_state_t state;
    rre_instr_t held;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] wreg;
    logic carry;
    logic gie;
    logic irqAck;
    logic busy;
    logic [DATA_W-1:0] raddr;
    rre_memwr_t wr;
  } rre_core_t;

  rre_core_t r;
  rre_core_t next_r;
  logic push;
  logic pop;
  logic [PC_W-1:0] pushData;
  logic [PC_W-1:0] stackTop;
  logic [DATA_W-1:0] rolv;
  logic [DATA_W-1:0] rlcv;
  logic [DATA_W-1:0] rorv;

  // Calls and interrupt entry push, returns pop
  rre_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .push(push),
    .pop(pop),
    .pushData(pushData),
    .topData(stackTop)
  );

  // Memory data is used in the same cycle that the registered read address is presented
  always_comb begin
    rolv = {memRdata[MSB_POS-1:LSB_POS], memRdata[MSB_POS]};
    // Carry enters as it stood before this instruction
    rlcv = {memRdata[MSB_POS-1:LSB_POS], r.carry};
    rorv = {memRdata[LSB_POS], memRdata[MSB_POS:LSB_POS+1]};
  end

  // Write strobe and acknowledge fall back low unless set again
  always_comb begin
    next_r = r;
    next_r.wr.we = 1'b0;
    next_r.irqAck = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    pushData = r.pc;
    unique case (r.state)
      ST_EXEC: begin
        if (instr.valid) begin
          next_r.held = instr;
          next_r.pc = instr.nextPc;
          unique case (instr.op)
            OP_RETURN: begin
              pop = 1'b1;
              next_r.pc = stackTop;
            end
            OP_RETURN_LOAD_IMMEDIATE: begin
              pop = 1'b1;
              next_r.pc = stackTop;
              next_r.wreg = instr.imm;
            end
            OP_RETURN_FROM_INTERRUPT: begin
              pop = 1'b1;
              next_r.pc = stackTop;
              next_r.gie = 1'b1;
              // Pending request taken before the restored address runs
              if (irqPending) begin
                next_r.state = ST_IRQ;
                next_r.busy = 1'b1;
              end
            end
            OP_CALL: begin
              push = 1'b1;
              pushData = instr.nextPc;
              next_r.pc = instr.target;
            end
            OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_WREG, OP_ROTATE_LEFT_THRU_CARRY,
            OP_ROTATE_LEFT_THRU_CARRY_TO_WREG, OP_ROTATE_RIGHT_MEM: begin
              next_r.raddr = instr.addr;
              next_r.state = ST_MEMREAD;
              next_r.busy = 1'b1;
            end
            default: begin
              // Other codes only advance to the next address
            end
          endcase
          // Return-from-interrupt already decided on entry above
          if (instr.op != OP_RETURN_FROM_INTERRUPT && irqPending && r.gie) begin
            next_r.state = ST_IRQ;
            next_r.busy = 1'b1;
          end
          // Rotates finish their write-back first; the request waits a cycle
          if (instr.op inside {OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_WREG,
              OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY_TO_WREG,
              OP_ROTATE_RIGHT_MEM}) begin
            next_r.state = ST_MEMREAD;
          end
        end else if (irqPending && r.gie) begin
          next_r.state = ST_IRQ;
          next_r.busy = 1'b1;
        end
      end
      ST_MEMREAD: begin
        // Write-back targets the address held from the request
        next_r.wr.addr = r.held.addr;
        next_r.state = ST_EXEC;
        next_r.busy = 1'b0;
        unique case (r.held.op)
          OP_ROTATE_LEFT_MEM: begin
            next_r.wr.we = 1'b1;
            next_r.wr.wdata = rolv;
          end
          OP_ROTATE_LEFT_TO_WREG: begin
            // Strobe stays low so the memory byte is untouched
            next_r.wreg = rolv;
          end
          OP_ROTATE_LEFT_THRU_CARRY: begin
            next_r.wr.we = 1'b1;
            next_r.wr.wdata = rlcv;
            next_r.carry = memRdata[MSB_POS];
          end
          OP_ROTATE_LEFT_THRU_CARRY_TO_WREG: begin
            next_r.wreg = rlcv;
            next_r.carry = memRdata[MSB_POS];
          end
          OP_ROTATE_RIGHT_MEM: begin
            next_r.wr.we = 1'b1;
            next_r.wr.wdata = rorv;
          end
          default: begin
            // Only rotates enter this state; any other held code writes nothing
            next_r.wr.we = 1'b0;
          end
        endcase
        if (irqPending && r.gie) begin
          next_r.state = ST_IRQ;
          next_r.busy = 1'b1;
        end
      end
      ST_IRQ: begin
        // Entry clears the enable, so nesting needs an explicit re-arm
        // Resume address saved so the handler's return lands there
        push = 1'b1;
        pushData = r.pc;
        next_r.pc = IRQ_VECTOR;
        next_r.gie = 1'b0;
        next_r.irqAck = 1'b1;
        next_r.state = ST_EXEC;
        next_r.busy = 1'b0;
      end
      default: begin
        next_r.state = ST_EXEC;
        next_r.busy = 1'b0;
      end
    endcase
  end

  // Reset overrides the enable so a frozen core can still be cleared
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r.state <= ST_EXEC;
      r.held <= '0;
      r.pc <= PC_RESET;
      r.wreg <= WREG_RESET;
      r.carry <= CARRY_RESET;
      r.gie <= GIE_RESET;
      r.irqAck <= 1'b0;
      r.busy <= 1'b0;
      r.raddr <= '0;
      r.wr <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // Every output is a bare copy of a state flop
  always_comb begin
    busy = r.busy;
    pc = r.pc;
    wreg = r.wreg;
    carry = r.carry;
    globalIntEnable = r.gie;
    irqAck = r.irqAck;
    memRaddr = r.raddr;
    memWr = r.wr;
  end
endmodule

/* verification/rre_core_checker.sv */
// Port assertions and covers for the return/rotate unit
module rre_core_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input rre_pkg::rre_instr_t instr,
  input wire logic irqPending,
  input wire logic [rre_pkg::DATA_W-1:0] memRdata,
  input wire logic busy,
  input wire logic [rre_pkg::PC_W-1:0] pc,
  input wire logic [rre_pkg::DATA_W-1:0] wreg,
  input wire logic carry,
  input wire logic globalIntEnable,
  input wire logic irqAck,
  input rre_pkg::rre_memwr_t memWr
);
  import rre_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic go;
  logic [7:0] rd;
  assign go = ce && !busy && instr.valid;
  // Read data one edge back, as the write-back stage sees it
  always_ff @(posedge clk_sys) rd <= memRdata;
  sequence take(rre_op_t o);
    go && instr.op == o ##1 1'b1;
  endsequence
  rol_mem_a: assert property (take(OP_ROTATE_LEFT_MEM) |=> memWr.we &&
    memWr.wdata == {rd[6:0], rd[7]} && $stable(carry)) else $error("rotate left");
  ror_mem_a: assert property (take(OP_ROTATE_RIGHT_MEM) |=> memWr.we &&
    memWr.wdata == {rd[0], rd[7:1]} && $stable(carry)) else $error("rotate right");
  rol_wreg_a: assert property (take(OP_ROTATE_LEFT_TO_WREG) |=> !memWr.we &&
    wreg == {rd[6:0], rd[7]} && $stable(carry)) else $error("rotate to wreg");
  rlc_mem_a: assert property (take(OP_ROTATE_LEFT_THRU_CARRY) |=> memWr.we &&
    memWr.wdata == {rd[6:0], $past(carry, 2)} && carry == rd[7]) else $error("carry rotate");
  rlc_wreg_a: assert property (take(OP_ROTATE_LEFT_THRU_CARRY_TO_WREG) |=>
    !memWr.we && wreg == {rd[6:0], $past(carry, 2)} && carry == rd[7]) else $error("rlc wreg");
  ret_imm_a: assert property (go && instr.op == OP_RETURN_LOAD_IMMEDIATE |=>
    wreg == $past(instr.imm) && $stable(carry)) else $error("return immediate");
  return_from_interrupt_gie_a: assert property (go && instr.op == OP_RETURN_FROM_INTERRUPT |=>
    globalIntEnable) else $error("interrupt enable");
  return_from_interrupt_irq_a: assert property (go && instr.op == OP_RETURN_FROM_INTERRUPT &&
    irqPending ##1 irqPending |=> irqAck && pc == IRQ_VECTOR) else $error("pending irq");
  ret_flags_a: assert property (go && instr.op == OP_RETURN |=>
    $stable(carry) && $stable(wreg)) else $error("plain return");
  cover property (irqAck);
  cover property (memWr.we);
  cover property (take(OP_RETURN_LOAD_IMMEDIATE));
  cover property (go && instr.op == OP_RETURN_FROM_INTERRUPT && irqPending);
endmodule

bind rre_core rre_core_checker chk_u (
  .clk_sys(clk_sys),
  .srst(srst),
  .ce(ce),
  .instr(instr),
  .irqPending(irqPending),
  .memRdata(memRdata),
  .busy(busy),
  .pc(pc),
  .wreg(wreg),
  .carry(carry),
  .globalIntEnable(globalIntEnable),
  .irqAck(irqAck),
  .memWr(memWr)
);

/* verification/tb_return_and_rotate_execution.sv */
// Directed bench for the return/rotate unit
module tb_return_and_rotate_execution;
  timeunit 1ns;
  timeprecision 1ns;
  import rre_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic irqPending = 1'b0;
  logic [7:0] memRdata = 8'h00;
  rre_instr_t instr = '0;
  logic busy, carry, globalIntEnable, irqAck, c;
  logic [10:0] pc;
  logic [7:0] wreg, memRaddr;
  rre_memwr_t memWr;
  int nErrors = 0;
  int numChecks = 0;
  always #20 clk_sys = ~clk_sys;
  rre_core dut_u (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .instr(instr),
    .irqPending(irqPending),
    .memRdata(memRdata),
    .busy(busy),
    .pc(pc),
    .wreg(wreg),
    .carry(carry),
    .globalIntEnable(globalIntEnable),
    .irqAck(irqAck),
    .memRaddr(memRaddr),
    .memWr(memWr)
  );
  task chk(input logic [10:0] s, e);
    numChecks++;
    if (s !== e) begin
      nErrors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task results;
    if (nErrors == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task rst;
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    c = 1'b0;
  endtask
  // Idle cycle between requests keeps valid from toggling twice in one step
  task issue(input rre_op_t o, input logic [10:0] x);
    @(negedge clk_sys);
    instr = '{1'b1, o, x[7:0], x[7:0], x, x + 11'h001};
    @(negedge clk_sys);
    instr.valid = 1'b0;
  endtask
  task rot(input rre_op_t o, input logic [7:0] d);
    logic [7:0] r;
    logic nc, w;
    r = {d[6:0], d[7]};
    nc = c;
    w = o != OP_ROTATE_LEFT_TO_WREG;
    if (o == OP_ROTATE_RIGHT_MEM) r = {d[0], d[7:1]};
    if (o == OP_ROTATE_LEFT_THRU_CARRY || o == OP_ROTATE_LEFT_THRU_CARRY_TO_WREG) begin
      r = {d[6:0], c};
      nc = d[7];
      w = o == OP_ROTATE_LEFT_THRU_CARRY;
    end
    issue(o, {3'h0, ~d});
    chk(memRaddr, {3'h0, ~d});
    chk(busy, 11'h001);
    memRdata = d;
    @(negedge clk_sys);
    // Released bus shows a changed value, not the old byte
    memRdata = ~d;
    chk(memWr.we, w);
    chk(memWr.addr, {3'h0, ~d});
    chk(w ? memWr.wdata : wreg, r);
    chk(carry, nc);
    chk(busy, 11'h000);
    c = nc;
  endtask
  task t_rot;
    rot(OP_ROTATE_LEFT_MEM, 8'h81);
    rot(OP_ROTATE_LEFT_THRU_CARRY, 8'h81);
    rot(OP_ROTATE_LEFT_THRU_CARRY_TO_WREG, 8'h40);
    rot(OP_ROTATE_LEFT_TO_WREG, 8'h80);
    rot(OP_ROTATE_RIGHT_MEM, 8'h01);
    rot(OP_ROTATE_LEFT_THRU_CARRY, 8'h80);
    @(negedge clk_sys);
    chk(memWr.we, 1'b0);
  endtask
  task t_stack;
    issue(OP_CALL, 11'h100);
    issue(OP_CALL, 11'h200);
    issue(OP_CALL, 11'h300);
    issue(OP_RETURN_LOAD_IMMEDIATE, 11'h0a5);
    chk(pc, 11'h301);
    chk(wreg, 11'h0a5);
    chk(carry, c);
    issue(OP_RETURN, 11'h000);
    chk(pc, 11'h201);
    chk(carry, c);
    issue(OP_RETURN_FROM_INTERRUPT, 11'h000);
    chk(pc, 11'h101);
    chk(globalIntEnable, 11'h001);
    chk(carry, c);
  endtask
  task t_irq;
    issue(OP_CALL, 11'h050);
    irqPending = 1'b1;
    issue(OP_RETURN_FROM_INTERRUPT, 11'h000);
    chk(pc, 11'h051);
    chk(globalIntEnable, 11'h001);
    chk(busy, 11'h001);
    @(negedge clk_sys);
    chk(irqAck, 11'h001);
    chk(pc, IRQ_VECTOR);
    chk(busy, 11'h000);
    irqPending = 1'b0;
    issue(OP_RETURN, 11'h000);
    chk(irqAck, 11'h000);
    chk(pc, 11'h051);
  endtask
  // Enable low must freeze everything, the stack included
  task t_ce;
    ce = 1'b0;
    issue(OP_RETURN_LOAD_IMMEDIATE, 11'h03c);
    chk(pc, 11'h051);
    chk(wreg, 11'h000);
    ce = 1'b1;
    issue(OP_RETURN_LOAD_IMMEDIATE, 11'h03c);
    chk(wreg, 11'h03c);
  endtask
  initial begin
    rst();
    t_rot();
    t_stack();
    rst();
    t_irq();
    t_ce();
    results();
  end
endmodule
